// [ssf_err_flags.sv]
`timescale 1ns/100ps

// shared constants and carriers of the serial status flag block
package ssf_pkg;

  // register bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] FLAGS_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] MASK_OFS = 12'h004;

  // field positions of the status flag word
  localparam int TX_IRQ_BIT = 15;
  localparam int RX_IRQ_BIT = 14;
  localparam int TX_CNT_LSB = 11;
  localparam int RX_CNT_LSB = 8;
  localparam int CNT_W = 3;
  localparam int OVW_BIT = 7;
  localparam int STARVE_BIT = 6;
  localparam int FMT_BIT = 5;
  localparam int GAP_BIT = 3;
  localparam int IDLE_BIT = 2;
  localparam int TXRDY_BIT = 1;
  localparam int RXRDY_BIT = 0;

  // byte lane that carries the error bits
  localparam int ERR_LANE = 0;

  // error flag indices inside the sticky flag module
  localparam int ERR_N = 3;
  localparam int ERR_OVW = 0;
  localparam int ERR_STARVE = 1;
  localparam int ERR_FMT = 2;

  // queue depth in frames and empty count
  localparam logic [CNT_W-1:0] QUEUE_DEPTH = 3'h4;
  localparam logic [CNT_W-1:0] QUEUE_EMPTY = 3'h0;

  // reset values and masks
  localparam logic [DATA_W-1:0] FLAGS_RESET = 32'h0000_8006;
  localparam logic [DATA_W-1:0] MASK_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] FLAGS_USED = 32'h0000_FFEF;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  // apb request from the bus master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [STRB_W-1:0] pstrb;
  } ssf_apb_req_t;

  // apb answer of this slave
  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } ssf_apb_rsp_t;

  // indications from shift engine, queues and timers
  typedef struct packed {
    logic [CNT_W-1:0] tx_fill_count;
    logic [CNT_W-1:0] rx_fill_count;
    logic tx_fill_irq_cond;
    logic rx_fill_irq_cond;
    logic transfer_active;
    logic frame_done;
    logic gap_release;
    logic slave_mode;
    logic config_mode;
    logic master_stop_control;
    logic rx_overwrite_evt;
    logic tx_starve_evt;
    logic format_violation_evt;
  } ssf_core_in_t;

endpackage : ssf_pkg

// sticky error flags, set by events, cleared by write-one
module ssf_err_flags
  import ssf_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [ERR_N-1:0] set_evt,
  input wire logic [ERR_N-1:0] clr_w1c,
  input wire logic [ERR_N-1:0] enable,
  input wire logic cfg_clear,
  output logic [ERR_N-1:0] flags
);

  genvar i;

  // one flop per flag; an event in a write-one clear cycle is kept, one in a config clear cycle is lost
  generate
    for (i = 0; i < ERR_N; i++)
    begin : g_flag
      always_ff @(posedge clock)
      begin
        if (rst)
          flags[i] <= 1'b0;
        else if (cfg_clear)
          flags[i] <= 1'b0; // [RULE_09]
        else if (!enable[i])
          flags[i] <= 1'b0; // [RULE_06] [RULE_07]
        else if (set_evt[i])
          flags[i] <= 1'b1; // [RULE_08]
        else if (clr_w1c[i])
          flags[i] <= 1'b0; // [RULE_01]
      end
    end
  endgenerate

endmodule : ssf_err_flags

// [ssf_status_top.sv]
// Functional notes
// RULE_01 - status read-only, errors cleared by writing one
// RULE_02 - bits 13:11 show queued transmit words
// RULE_03 - bits 10:8 show stored received words
// RULE_04 - bit 15 transmit fill interrupt, resets one
// RULE_05 - bit 14 receive fill interrupt, resets zero
// RULE_06 - bit 7 receive overwrite, slave mode only
// RULE_07 - bit 6 transmit starvation, slave mode only
// RULE_08 - bit 5 transfer format violation, write-one clear
// RULE_09 - configuration mode clears all three errors
// RULE_10 - bit 3 high between frame end and release
// RULE_11 - bit 2 idle: no transfer, empty or stopped
// RULE_12 - bit 1 high while transmit queue not full
// RULE_13 - bit 0 high while receive word queued
// RULE_14 - both queues hold at most four frames
// RULE_15 - bits 31:16 and 4 read zero
`timescale 1ns/100ps

module ssf_status_top
(
  input wire logic clock,
  input wire logic rst,
  input wire ssf_pkg::ssf_apb_req_t apb_req,
  output ssf_pkg::ssf_apb_rsp_t apb_rsp,
  input wire ssf_pkg::ssf_core_in_t core_in,
  output logic [ssf_pkg::DATA_W-1:0] status_flags,
  output logic irq
);

  import ssf_pkg::*;

  // apb phase of this slave
  typedef enum logic [0:0] {
    SSF_IDLE,
    SSF_ACCESS
  } ssf_phase_t;

  ssf_phase_t phase_reg;
  ssf_phase_t phase_next;
  ssf_apb_rsp_t rsp_reg;
  ssf_apb_rsp_t rsp_next;
  logic [DATA_W-1:0] flags_reg;
  logic [DATA_W-1:0] flags_next;
  logic [DATA_W-1:0] mask_reg;
  logic [DATA_W-1:0] mask_next;
  logic gap_reg;
  logic gap_next;
  logic irq_reg;
  logic [ERR_N-1:0] err_flags;
  logic [ERR_N-1:0] err_set;
  logic [ERR_N-1:0] err_clr;
  logic [ERR_N-1:0] err_enable;
  logic setup_cycle;
  logic write_fire;
  logic flags_write;
  logic mask_write;
  logic [CNT_W-1:0] tx_count;
  logic [CNT_W-1:0] rx_count;
  logic [DATA_W-1:0] lane_mask;

  // true when the address selects the given word
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  // true for any implemented word
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
    addr_mapped = reg_hit(addr, FLAGS_OFS) || reg_hit(addr, MASK_OFS);
  endfunction : addr_mapped

  // limit a queue count to the queue depth
  function automatic logic [CNT_W-1:0] sat_count(
    input logic [CNT_W-1:0] cnt);
    if (cnt > QUEUE_DEPTH)
      sat_count = QUEUE_DEPTH;
    else
      sat_count = cnt;
  endfunction : sat_count

  // bus qualifiers
  assign setup_cycle = apb_req.psel && !apb_req.penable;
  assign write_fire = apb_req.psel && apb_req.penable && rsp_reg.pready &&
                      apb_req.pwrite;
  assign flags_write = write_fire && reg_hit(apb_req.paddr, FLAGS_OFS);
  assign mask_write = write_fire && reg_hit(apb_req.paddr, MASK_OFS);

  // expand byte strobes to a bit mask
  always_comb
  begin
    lane_mask = ZERO_WORD;
    for (int b = 0; b < STRB_W; b++)
      lane_mask[b*8 +: 8] = {8{apb_req.pstrb[b]}};
  end

  // queue counts never exceed four frames
  assign tx_count = sat_count(core_in.tx_fill_count); // [RULE_14]
  assign rx_count = sat_count(core_in.rx_fill_count); // [RULE_14]

  // error events, clears and slave-only gating
  always_comb
  begin
    err_set = ERR_N'(0);
    err_clr = ERR_N'(0);
    err_enable = {ERR_N{1'b1}};
    err_set[ERR_OVW] = core_in.rx_overwrite_evt; // [RULE_06]
    err_set[ERR_STARVE] = core_in.tx_starve_evt; // [RULE_07]
    err_set[ERR_FMT] = core_in.format_violation_evt; // [RULE_08]
    err_enable[ERR_OVW] = core_in.slave_mode; // [RULE_06]
    err_enable[ERR_STARVE] = core_in.slave_mode; // [RULE_07]
    if (flags_write && apb_req.pstrb[ERR_LANE])
    begin
      err_clr[ERR_OVW] = apb_req.pwdata[OVW_BIT]; // [RULE_01]
      err_clr[ERR_STARVE] = apb_req.pwdata[STARVE_BIT]; // [RULE_01]
      err_clr[ERR_FMT] = apb_req.pwdata[FMT_BIT]; // [RULE_01]
    end
  end

  // sticky error flags
  ssf_err_flags u_err_flags
  (
    .clock(clock),
    .rst(rst),
    .set_evt(err_set),
    .clr_w1c(err_clr),
    .enable(err_enable),
    .cfg_clear(core_in.config_mode), // [RULE_09]
    .flags(err_flags)
  );

  // frame gap indication: set at frame end, dropped on release
  always_comb
  begin
    gap_next = gap_reg;
    if (core_in.frame_done)
      gap_next = 1'b1; // [RULE_10]
    else if (core_in.gap_release)
      gap_next = 1'b0; // [RULE_10]
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      gap_reg <= 1'b0;
    else
      gap_reg <= gap_next;
  end

  // assemble the status flag word; unused bits stay zero
  always_comb
  begin
    flags_next = ZERO_WORD; // [RULE_15]
    flags_next[TX_IRQ_BIT] = core_in.tx_fill_irq_cond; // [RULE_04]
    flags_next[RX_IRQ_BIT] = core_in.rx_fill_irq_cond; // [RULE_05]
    flags_next[TX_CNT_LSB +: CNT_W] = tx_count; // [RULE_02]
    flags_next[RX_CNT_LSB +: CNT_W] = rx_count; // [RULE_03]
    flags_next[OVW_BIT] = err_flags[ERR_OVW] &&
                          core_in.slave_mode; // [RULE_06]
    flags_next[STARVE_BIT] = err_flags[ERR_STARVE] &&
                             core_in.slave_mode; // [RULE_07]
    flags_next[FMT_BIT] = err_flags[ERR_FMT]; // [RULE_08]
    flags_next[GAP_BIT] = gap_reg; // [RULE_10]
    flags_next[IDLE_BIT] = !core_in.transfer_active &&
                           ((tx_count == QUEUE_EMPTY) ||
                            (!core_in.slave_mode &&
                             core_in.master_stop_control)); // [RULE_11]
    flags_next[TXRDY_BIT] = (tx_count != QUEUE_DEPTH); // [RULE_12]
    flags_next[RXRDY_BIT] = (rx_count != QUEUE_EMPTY); // [RULE_13]
    flags_next = flags_next & FLAGS_USED; // [RULE_15]
  end

  // flag word register, reset pattern has bits 15, 2 and 1 set
  always_ff @(posedge clock)
  begin
    if (rst)
      flags_reg <= FLAGS_RESET; // [RULE_04] [RULE_11] [RULE_12]
    else
      flags_reg <= flags_next;
  end

  // interrupt mask, written per byte lane
  always_comb
  begin
    mask_next = mask_reg;
    if (mask_write)
      mask_next = ((mask_reg & ~lane_mask) |
                   (apb_req.pwdata & lane_mask)) & FLAGS_USED;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      mask_reg <= MASK_RESET;
    else
      mask_reg <= mask_next;
  end

  // level interrupt while any unmasked flag is set
  always_ff @(posedge clock)
  begin
    if (rst)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(flags_reg & mask_reg);
  end

  // apb phase tracking and answer
  always_comb
  begin
    phase_next = phase_reg;
    rsp_next = rsp_reg;
    case (phase_reg)
      SSF_IDLE:
      begin
        rsp_next.pready = 1'b0;
        rsp_next.pslverr = 1'b0;
        if (setup_cycle)
        begin
          phase_next = SSF_ACCESS;
          rsp_next.pready = 1'b1; // answer in the first access cycle
          rsp_next.pslverr = !addr_mapped(apb_req.paddr);
          rsp_next.prdata = ZERO_WORD;
          if (!apb_req.pwrite && reg_hit(apb_req.paddr, FLAGS_OFS))
            rsp_next.prdata = flags_reg; // [RULE_01]
          else if (!apb_req.pwrite && reg_hit(apb_req.paddr, MASK_OFS))
            rsp_next.prdata = mask_reg;
        end
      end
      SSF_ACCESS:
      begin
        // transfer ends at this edge; back to back setup follows
        phase_next = SSF_IDLE;
        rsp_next.pready = 1'b0;
        rsp_next.pslverr = 1'b0;
      end
      default:
      begin
        phase_next = SSF_IDLE;
        rsp_next.pready = 1'b0;
        rsp_next.pslverr = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      phase_reg <= SSF_IDLE;
      rsp_reg <= '0;
    end
    else
    begin
      phase_reg <= phase_next;
      rsp_reg <= rsp_next;
    end
  end

  // outputs straight from flops
  assign apb_rsp = rsp_reg;
  assign status_flags = flags_reg;
  assign irq = irq_reg;

endmodule : ssf_status_top

// [ssf_core_model.sv]
`timescale 1ns/100ps

// far side: queues, shift engine and timers seen by the flag block
module ssf_core_model
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] rnd,
  input wire logic [2:0] ev,
  input wire logic cfg,
  input wire logic slave,
  output ssf_pkg::ssf_core_in_t core_in
);
  import ssf_pkg::*;
  logic [CNT_W-1:0] tx_reg;
  logic [CNT_W-1:0] rx_reg;

  // fill counts walk by one and stop at empty and full
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      tx_reg <= QUEUE_EMPTY;
      rx_reg <= QUEUE_EMPTY;
    end
    else
    begin
      if (rnd[0] && !rnd[1] && tx_reg < QUEUE_DEPTH)
        tx_reg <= tx_reg + 3'h1;
      else if (rnd[1] && !rnd[0] && tx_reg != QUEUE_EMPTY)
        tx_reg <= tx_reg - 3'h1;
      if (rnd[2] && !rnd[3] && rx_reg < QUEUE_DEPTH)
        rx_reg <= rx_reg + 3'h1;
      else if (rnd[3] && !rnd[2] && rx_reg != QUEUE_EMPTY)
        rx_reg <= rx_reg - 3'h1;
    end
  end

  // levels and pulses handed to the flag block
  always_comb
  begin
    core_in.tx_fill_count = tx_reg;
    core_in.rx_fill_count = rx_reg;
    core_in.tx_fill_irq_cond = tx_reg < 3'h2;
    core_in.rx_fill_irq_cond = rx_reg > 3'h2;
    core_in.transfer_active = rnd[4];
    core_in.frame_done = rnd[5] & rnd[6];
    core_in.gap_release = rnd[7] & ~rnd[6];
    core_in.slave_mode = slave;
    core_in.config_mode = cfg;
    core_in.master_stop_control = rnd[8];
    core_in.rx_overwrite_evt = ev[0];
    core_in.tx_starve_evt = ev[1];
    core_in.format_violation_evt = ev[2];
  end
endmodule : ssf_core_model

// [ssf_status_properties.sv]
`timescale 1ns/100ps

// flag word relations watched at the block ports
module ssf_status_properties
(
  input wire logic clock,
  input wire logic rst,
  input wire ssf_pkg::ssf_apb_req_t apb_req,
  input wire ssf_pkg::ssf_apb_rsp_t apb_rsp,
  input wire ssf_pkg::ssf_core_in_t core_in,
  input wire logic [ssf_pkg::DATA_W-1:0] status_flags,
  input wire logic irq
);
  import ssf_pkg::*;
  logic [31:0] sf;
  ssf_core_in_t c;
  logic [2:0] txc;
  logic [2:0] rxc;
  logic idl;

  // short names and clamped counts
  assign sf = status_flags;
  assign c = core_in;
  assign txc = c.tx_fill_count > 3'h4 ? 3'h4 : c.tx_fill_count;
  assign rxc = c.rx_fill_count > 3'h4 ? 3'h4 : c.rx_fill_count;
  assign idl = !c.transfer_active &&
    (txc == 3'h0 || (!c.slave_mode && c.master_stop_control));

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_tx_cnt;
    !$past(rst) |-> sf[13:11] == $past(txc);
  endproperty
  property p_rx_cnt;
    !$past(rst) |-> sf[10:8] == $past(rxc);
  endproperty
  property p_idle;
    !$past(rst) |-> sf[2] == $past(idl);
  endproperty
  property p_txrdy;
    !$past(rst) |-> sf[1] == ($past(txc) != 3'h4);
  endproperty
  property p_rxrdy;
    !$past(rst) |-> sf[0] == ($past(rxc) != 3'h0);
  endproperty
  property p_unused;
    sf[31:16] == 16'h0000 && !sf[4];
  endproperty
  property p_master;
    !c.slave_mode [*2] |-> ##1 sf[7:6] == 2'h0;
  endproperty
  property p_fmt;
    c.format_violation_evt && !c.config_mode ##1 !c.config_mode |-> ##1 sf[5];
  endproperty
  property p_cfg;
    c.config_mode |-> ##2 sf[7:5] == 3'h0;
  endproperty
  property p_gap;
    c.frame_done |-> ##[1:2] sf[3];
  endproperty
  property p_gap_clr;
    c.gap_release && !c.frame_done |-> ##2 !sf[3];
  endproperty

  a_tx_cnt: assert property (p_tx_cnt)
    else $error("tx count field wrong");
  a_rx_cnt: assert property (p_rx_cnt)
    else $error("rx count field wrong");
  a_idle: assert property (p_idle)
    else $error("idle bit wrong");
  a_txrdy: assert property (p_txrdy)
    else $error("tx space bit wrong");
  a_rxrdy: assert property (p_rxrdy)
    else $error("rx word bit wrong");
  a_unused: assert property (p_unused)
    else $error("unused bits not zero");
  a_master: assert property (p_master)
    else $error("slave-only error set in master");
  a_fmt: assert property (p_fmt)
    else $error("format error not set");
  a_cfg: assert property (p_cfg)
    else $error("config mode left errors set");
  a_gap: assert property (p_gap)
    else $error("gap bit not set after frame");
  a_gap_clr: assert property (p_gap_clr)
    else $error("gap bit not cleared on release");

  c_frame: cover property (c.frame_done);
  c_errs: cover property (sf[7:5] == 3'h7);
  c_irq: cover property (irq);
endmodule : ssf_status_properties

bind ssf_status_top ssf_status_properties i_props (.clock(clock), .rst(rst),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .core_in(core_in),
  .status_flags(status_flags), .irq(irq));

// [tb_serial_port_status_flags.sv]
`timescale 1ns/100ps

// self-checking bench of the status flag block
module tb_serial_port_status_flags;
  import ssf_pkg::*;
  logic clock;
  logic rst;
  ssf_apb_req_t req;
  ssf_apb_rsp_t rsp;
  ssf_core_in_t core_in;
  logic [31:0] status_flags;
  logic irq;
  logic [15:0] rnd;
  logic [2:0] ev;
  logic cfg;
  logic slave;
  logic [31:0] rd;
  logic [31:0] exp;
  logic err;
  int seed;
  int errors;
  int compares;

  ssf_status_top i_dut (.clock(clock), .rst(rst), .apb_req(req),
    .apb_rsp(rsp), .core_in(core_in), .status_flags(status_flags),
    .irq(irq));
  ssf_core_model i_far (.clock(clock), .rst(rst), .rnd(rnd), .ev(ev),
    .cfg(cfg), .slave(slave), .core_in(core_in));

  // free-running system clock
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task results;
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want)
    begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, want);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // let n edges pass, then look at the settled falling edge
  task automatic look(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : look

  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s);
    @(posedge clock);
    req <= '{1'b1, 1'b0, wr, a, d, s};
    @(posedge clock);
    req.penable <= 1'b1;
    // no wait count assumed: pready ends this wait, and only the hang guard bounds it
    do
    begin
      @(posedge clock);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // flag word expected from the inputs one cycle earlier
  function automatic logic [31:0] exp_flags(input ssf_core_in_t c);
    logic [2:0] t;
    logic [2:0] r;
    t = c.tx_fill_count > 3'h4 ? 3'h4 : c.tx_fill_count;
    r = c.rx_fill_count > 3'h4 ? 3'h4 : c.rx_fill_count;
    exp_flags = {16'h0, c.tx_fill_irq_cond, c.rx_fill_irq_cond, t, r, 8'h0};
    exp_flags[2] = !c.transfer_active &&
      (t == 3'h0 || (!c.slave_mode && c.master_stop_control));
    exp_flags[1] = t != 3'h4;
    exp_flags[0] = r != 3'h0;
  endfunction : exp_flags

  // main sequence
  initial
  begin
    seed = 6;
    errors = 0;
    compares = 0;
    rst = 1'b1;
    req = '0;
    rnd = 16'h0;
    ev = 3'h0;
    cfg = 1'b0;
    slave = 1'b1;
    tick(4);
    rst <= 1'b0;
    @(negedge clock);
    chk(status_flags, 32'h0000_8006);
    apb(1'b0, FLAGS_OFS, 32'h0, 4'hF);
    chk(rd, 32'h0000_8006);
    apb(1'b0, 12'h008, 32'h0, 4'hF);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, MASK_OFS, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, MASK_OFS, 32'h0, 4'hF);
    chk(rd, FLAGS_USED);
    apb(1'b1, MASK_OFS, 32'h0000_00E0, 4'hF);
    ev <= 3'h7;
    tick(1);
    ev <= 3'h0;
    look(3);
    chk({28'h0, irq, status_flags[7:5]}, 32'hF);
    apb(1'b1, FLAGS_OFS, 32'h0000_00E0, 4'hE);
    look(2);
    chk({28'h0, irq, status_flags[7:5]}, 32'hF);
    apb(1'b1, FLAGS_OFS, 32'hFFFF_FF3F, 4'hF);
    look(3);
    chk({28'h0, irq, status_flags[7:5]}, 32'hE);
    tick(1);
    cfg <= 1'b1;
    tick(2);
    cfg <= 1'b0;
    look(3);
    chk({28'h0, irq, status_flags[7:5]}, 32'h0);
    tick(1);
    slave <= 1'b0;
    tick(1);
    ev <= 3'h7;
    tick(1);
    ev <= 3'h0;
    look(3);
    chk({28'h0, irq, status_flags[7:5]}, 32'h9);
    apb(1'b1, FLAGS_OFS, 32'h0000_0020, 4'hF);
    look(3);
    chk({28'h0, irq, status_flags[7:5]}, 32'h0);
    // expectation taken at the falling edge, before the sampling edge
    repeat (300)
    begin
      exp = exp_flags(core_in);
      @(posedge clock);
      rnd <= 16'($random(seed));
      slave <= rnd[9];
      @(negedge clock);
      chk(status_flags & 32'hFFFF_FF17, exp);
    end
    results();
  end

  // hang guard
  initial
  begin
    #1000000;
    errors++;
    results();
  end
endmodule : tb_serial_port_status_flags
